// ### hdl/remote_error_queue_pkg.sv
// Function
// - Thirty-entry FIFO; full replaces newest with -350.
// - Next-error read returns oldest entry, removes it.
// - Queue empties on reset, clear-status, drain.
// - Persisting condition re-queued after every clear.
// - Empty queue answers code zero, no-error.
// - Every error also forwarded to front panel.
// - Answer carries code and description identifier.
// - Each error sets at most one class bit; codes outside every class set none.
// - Codes -499..-400 set status bit 2.
// - Output queue faults raise query errors.
// - Device codes set status bit 3.
// - Self-test failure uses a device-specific code.
// - Positive codes 201..703 and 800..810 are device faults, own text.
// - Codes -299..-200 set status bit 4.
// - Range or state conflicts raise execution errors.
// - Range check sees only rounded values.
// - Codes -199..-100 set status bit 5.
// - Parser faults raise command errors.
// - Reading or clear-status may drop error indicator.
`default_nettype none

package remote_error_queue_pkg;

  localparam int QUEUE_DEPTH = 30;

  // Register offsets on the command port.
  localparam logic [7:0] ADR_NEXT = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_CONTROL = 8'h08;
  localparam logic [7:0] ADR_LIMIT_LO = 8'h0c;
  localparam logic [7:0] ADR_LIMIT_HI = 8'h10;

  // Field positions.
  localparam int ESR_QUERY_BIT = 2;
  localparam int ESR_DEVICE_BIT = 3;
  localparam int ESR_EXEC_BIT = 4;
  localparam int ESR_CMD_BIT = 5;
  localparam int STATUS_COUNT_LSB = 8;
  localparam int STATUS_IND_BIT = 16;
  localparam int CTRL_CLS_BIT = 0;
  localparam int CTRL_IND_EN_BIT = 1;

  // Values after reset.
  localparam logic [7:0] ESR_RESET = 8'h00;
  localparam logic IND_EN_RESET = 1'b1;
  localparam logic [15:0] LIMIT_LO_RESET = 16'h8000;
  localparam logic [15:0] LIMIT_HI_RESET = 16'h7fff;

  // Codes and description identifiers.
  localparam logic [15:0] CODE_NO_ERROR = 16'h0000;
  localparam logic [15:0] DESC_NO_ERROR = 16'h0000;
  localparam logic [15:0] CODE_OVERFLOW = 16'hfea2;
  localparam logic [15:0] DESC_OVERFLOW = 16'h0100;
  localparam logic [15:0] CODE_UNTERMINATED = 16'hfe5c;
  localparam logic [15:0] CODE_DATA_LOST = 16'hfe66;
  localparam logic [15:0] CODE_OUT_OF_RANGE = 16'hff22;
  localparam logic [15:0] CODE_SETTINGS_CONFLICT = 16'hff23;
  localparam logic [15:0] CODE_SYNTAX = 16'hff9a;
  localparam logic [15:0] CODE_DATA_TYPE = 16'hff98;
  localparam logic [15:0] CODE_HEADER = 16'hff8f;
  localparam logic [15:0] CODE_SELF_TEST = 16'hfeb6;
  localparam logic [15:0] CODE_UNLOCK = 16'h0201;

  // Class bounds, signed 16-bit.
  localparam logic signed [15:0] QUERY_LO = 16'hfe0d;
  localparam logic signed [15:0] QUERY_HI = 16'hfe70;
  localparam logic signed [15:0] DEVICE_LO = 16'hfe71;
  localparam logic signed [15:0] DEVICE_HI = 16'hfed4;
  localparam logic signed [15:0] EXEC_LO = 16'hfed5;
  localparam logic signed [15:0] EXEC_HI = 16'hff38;
  localparam logic signed [15:0] CMD_LO = 16'hff39;
  localparam logic signed [15:0] CMD_HI = 16'hff9c;
  localparam logic signed [15:0] POS_A_LO = 16'h00c9;
  localparam logic signed [15:0] POS_A_HI = 16'h02bf;
  localparam logic signed [15:0] POS_B_LO = 16'h0320;
  localparam logic signed [15:0] POS_B_HI = 16'h032a;

  // Internal sources, in grant priority order.
  localparam int SRC_COUNT = 9;
  localparam int SRC_COND = 8;

endpackage

`default_nettype wire

// ### hdl/remote_error_queue.sv
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module remote_error_queue #(
  parameter int DEPTH = remote_error_queue_pkg::QUEUE_DEPTH
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // External error reports
  input wire logic ERR_VALID,
  input wire logic [15:0] ERR_CODE,
  input wire logic [15:0] ERR_DESC,
  // Internal error events
  input wire logic QUERY_UNTERMINATED,
  input wire logic QUERY_LOST,
  input wire logic PARAM_CHECK,
  input wire logic [15:0] PARAM_VALUE,
  input wire logic STATE_CONFLICT,
  input wire logic SYNTAX_ERR,
  input wire logic DATA_TYPE_ERR,
  input wire logic HEADER_ERR,
  input wire logic SELFTEST_FAIL,
  input wire logic COND_ACTIVE,
  // Front panel queue feed and indicator
  output logic FP_PUSH,
  output logic [15:0] FP_CODE,
  output logic [15:0] FP_DESC,
  output logic ERROR_INDICATOR
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int SN = remote_error_queue_pkg::SRC_COUNT;
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

  logic [15:0] mem_code [DEPTH];
  logic [15:0] mem_desc [DEPTH];
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] wr_prev;
  logic [CW-1:0] count;
  logic [7:0] esr;
  logic ind_en;
  logic [15:0] limit_lo;
  logic [15:0] limit_hi;
  logic [SN-1:0] pending;
  logic [SN-1:0] events;
  logic [SN-1:0] grant;
  logic cond_prev;
  logic requeue;
  logic range_fail;
  logic push;
  logic [15:0] push_code;
  logic [15:0] push_desc;
  logic [3:0] push_class;
  logic pop;
  logic read_next;
  logic cls;
  logic full;
  logic overflow;

  // Class vector is {command, execution, device, query}.
  function automatic logic [3:0] classify(input logic [15:0] code);
    logic signed [15:0] c;
    c = $signed(code);
    classify = 4'h0;
    if (c >= remote_error_queue_pkg::QUERY_LO && c <= remote_error_queue_pkg::QUERY_HI) begin
      classify = 4'h1;
    end else if ((c >= remote_error_queue_pkg::DEVICE_LO && c <= remote_error_queue_pkg::DEVICE_HI)
                 || (c >= remote_error_queue_pkg::POS_A_LO && c <= remote_error_queue_pkg::POS_A_HI)
                 || (c >= remote_error_queue_pkg::POS_B_LO && c <= remote_error_queue_pkg::POS_B_HI)) begin
      classify = 4'h2;
    end else if (c >= remote_error_queue_pkg::EXEC_LO && c <= remote_error_queue_pkg::EXEC_HI) begin
      classify = 4'h4;
    end else if (c >= remote_error_queue_pkg::CMD_LO && c <= remote_error_queue_pkg::CMD_HI) begin
      classify = 4'h8;
    end
  endfunction

  function automatic logic [15:0] source_code(input logic [SN-1:0] g);
    source_code = remote_error_queue_pkg::CODE_UNLOCK;
    if (g[0]) source_code = remote_error_queue_pkg::CODE_UNTERMINATED;
    if (g[1]) source_code = remote_error_queue_pkg::CODE_DATA_LOST;
    if (g[2]) source_code = remote_error_queue_pkg::CODE_OUT_OF_RANGE;
    if (g[3]) source_code = remote_error_queue_pkg::CODE_SETTINGS_CONFLICT;
    if (g[4]) source_code = remote_error_queue_pkg::CODE_SYNTAX;
    if (g[5]) source_code = remote_error_queue_pkg::CODE_DATA_TYPE;
    if (g[6]) source_code = remote_error_queue_pkg::CODE_HEADER;
    if (g[7]) source_code = remote_error_queue_pkg::CODE_SELF_TEST;
  endfunction

  function automatic logic [PW-1:0] advance(input logic [PW-1:0] p);
    advance = (p == LAST_SLOT) ? '0 : p + 1'b1;
  endfunction

  // Decoded bus strobes.
  assign read_next = RD && (ADDR == remote_error_queue_pkg::ADR_NEXT);
  assign pop = read_next && (count != '0);
  assign cls = WR && (ADDR == remote_error_queue_pkg::ADR_CONTROL)
               && WDATA[remote_error_queue_pkg::CTRL_CLS_BIT];

  // The value offered here is already rounded and evaluated, so rounding alone never trips it.
  assign range_fail = PARAM_CHECK && ($signed(PARAM_VALUE) < $signed(limit_lo)
                      || $signed(PARAM_VALUE) > $signed(limit_hi));

  assign events = {(COND_ACTIVE && !cond_prev) || (COND_ACTIVE && requeue), SELFTEST_FAIL, HEADER_ERR,
                   DATA_TYPE_ERR, SYNTAX_ERR, STATE_CONFLICT, range_fail, QUERY_LOST, QUERY_UNTERMINATED};

  // Lowest pending source wins; an external report blocks all of them for that cycle.
  assign grant = ERR_VALID ? '0 : (pending & (~pending + 1'b1));

  assign push = ERR_VALID || (pending != '0);
  assign push_code = ERR_VALID ? ERR_CODE : source_code(grant);
  assign push_desc = ERR_VALID ? ERR_DESC : {7'h00, grant};
  assign push_class = classify(push_code);
  assign full = (count == FULL_COUNT);
  assign overflow = push && full && !pop && !cls;
  assign wr_prev = (wr_ptr == '0) ? LAST_SLOT : wr_ptr - 1'b1;

  // Pending events; a new event in the grant cycle sets the bit again.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~grant) | events;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cond_prev <= 1'b0;
      requeue <= 1'b0;
    end else begin
      cond_prev <= COND_ACTIVE;
      requeue <= cls || (pop && count == CW'(1));
    end
  end

  // Queue pointers and fill count.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
    end else if (cls) begin
      rd_ptr <= '0;
      wr_ptr <= push ? PW'(1) : '0;
      count <= push ? CW'(1) : '0;
    end else begin
      if (pop) begin
        rd_ptr <= advance(rd_ptr);
      end
      if (push && !overflow) begin
        wr_ptr <= advance(wr_ptr);
      end
      if (push && !overflow && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !(push && !overflow)) begin
        count <= count - 1'b1;
      end
    end
  end

  // Storage carries no reset; only slots holding queued entries are ever read.
  always_ff @(posedge CLK) begin
    if (cls && push) begin
      mem_code[0] <= push_code;
      mem_desc[0] <= push_desc;
    end else if (overflow) begin
      mem_code[wr_prev] <= remote_error_queue_pkg::CODE_OVERFLOW;
      mem_desc[wr_prev] <= remote_error_queue_pkg::DESC_OVERFLOW;
    end else if (push && !cls) begin
      mem_code[wr_ptr] <= push_code;
      mem_desc[wr_ptr] <= push_desc;
    end
  end

  // Event status bits; setting wins over a same-cycle clear.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      esr <= remote_error_queue_pkg::ESR_RESET;
    end else begin
      esr <= (cls ? 8'h00 : esr) | (push ? {2'b00, push_class, 2'b00} : 8'h00);
    end
  end

  // Software control registers.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ind_en <= remote_error_queue_pkg::IND_EN_RESET;
      limit_lo <= remote_error_queue_pkg::LIMIT_LO_RESET;
      limit_hi <= remote_error_queue_pkg::LIMIT_HI_RESET;
    end else if (WR) begin
      if (ADDR == remote_error_queue_pkg::ADR_CONTROL) begin
        ind_en <= WDATA[remote_error_queue_pkg::CTRL_IND_EN_BIT];
      end
      if (ADDR == remote_error_queue_pkg::ADR_LIMIT_LO) begin
        limit_lo <= WDATA[15:0];
      end
      if (ADDR == remote_error_queue_pkg::ADR_LIMIT_HI) begin
        limit_hi <= WDATA[15:0];
      end
    end
  end

  // Front panel copy is independent: its own reads and clears never come back here.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      FP_PUSH <= 1'b0;
      FP_CODE <= '0;
      FP_DESC <= '0;
    end else begin
      FP_PUSH <= push;
      FP_CODE <= push_code;
      FP_DESC <= push_desc;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ERROR_INDICATOR <= 1'b0;
    end else if (push) begin
      ERROR_INDICATOR <= 1'b1;
    end else if (ind_en && (read_next || cls)) begin
      ERROR_INDICATOR <= 1'b0;
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= '0;
    end else if (!RD) begin
      RDATA <= '0;
    end else begin
      case (ADDR)
        remote_error_queue_pkg::ADR_NEXT: begin
          if (count != '0) begin
            RDATA <= {mem_desc[rd_ptr], mem_code[rd_ptr]};
          end else begin
            RDATA <= {remote_error_queue_pkg::DESC_NO_ERROR, remote_error_queue_pkg::CODE_NO_ERROR};
          end
        end
        remote_error_queue_pkg::ADR_STATUS: begin
          RDATA <= {15'h0000, ERROR_INDICATOR, 2'b00, 6'(count), esr};
        end
        remote_error_queue_pkg::ADR_CONTROL: begin
          RDATA <= {30'h00000000, ind_en, 1'b0};
        end
        remote_error_queue_pkg::ADR_LIMIT_LO: begin
          RDATA <= {16'h0000, limit_lo};
        end
        remote_error_queue_pkg::ADR_LIMIT_HI: begin
          RDATA <= {16'h0000, limit_hi};
        end
        default: begin
          RDATA <= '0;
        end
      endcase
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  a_count_bound: assert property (count <= FULL_COUNT)
    else $error("queue count above depth");
  a_overflow_code: assert property (overflow
    |=> mem_code[$past(wr_prev)] == remote_error_queue_pkg::CODE_OVERFLOW && count == FULL_COUNT)
    else $error("overflow did not mark newest entry");
  a_pop_oldest: assert property (pop && !cls |=> RDATA[15:0] == $past(mem_code[rd_ptr])
                                 && count == $past(count) - CW'(1) + CW'($past(push)))
    else $error("read did not return and remove oldest entry");
  a_clear_empties: assert property (cls && !push |=> count == '0 ##1 !(count > CW'(1)))
    else $error("clear-status left entries");
  a_requeue_cond: assert property (requeue && COND_ACTIVE |=> pending[remote_error_queue_pkg::SRC_COND])
    else $error("persisting condition not re-queued");
  a_empty_answer: assert property (read_next && count == '0 |=> RDATA == 32'h00000000)
    else $error("empty queue did not answer no-error");
  a_front_copy: assert property (push |=> FP_PUSH && FP_CODE == $past(push_code))
    else $error("error not copied to front panel");
  a_one_class: assert property ($onehot0(push_class))
    else $error("error fell into more than one class");
  a_query_bit: assert property (push && push_class == 4'h1 |=> esr[remote_error_queue_pkg::ESR_QUERY_BIT])
    else $error("query error did not set bit 2");
  a_exec_range: assert property (range_fail |=> pending[2] ##[0:10] (FP_PUSH
                                 && FP_CODE == remote_error_queue_pkg::CODE_OUT_OF_RANGE))
    else $error("range failure not reported in time");
  a_sticky_status: assert property (!cls |=> (esr & $past(esr)) == $past(esr))
    else $error("status bit dropped without clear-status");
  a_indicator_set: assert property (push |=> ERROR_INDICATOR)
    else $error("indicator not raised by error");

  // Class bits follow the class of whatever was pushed, reported or internal.
  a_device_bit: assert property (push && push_class == 4'h2
    |=> esr[remote_error_queue_pkg::ESR_DEVICE_BIT])
    else $error("device error did not set bit 3");
  a_exec_bit: assert property (push && push_class == 4'h4
    |=> esr[remote_error_queue_pkg::ESR_EXEC_BIT])
    else $error("execution error did not set bit 4");
  a_cmd_bit: assert property (push && push_class == 4'h8
    |=> esr[remote_error_queue_pkg::ESR_CMD_BIT])
    else $error("command error did not set bit 5");
  a_status_clear: assert property (cls && !push
    |=> esr == 8'h00)
    else $error("clear-status left status bits");
  a_positive_device: assert property (push && !push_code[15] && push_class != 4'h0
    |-> push_class == 4'h2)
    else $error("positive code outside device class");

  // Internal sources must land in the class that their code belongs to.
  a_query_source: assert property (grant[0] || grant[1]
    |-> push_class == 4'h1)
    else $error("output queue fault not a query error");
  a_state_source: assert property (grant[2] || grant[3]
    |-> push_class == 4'h4)
    else $error("range or state fault not an execution error");
  a_parser_source: assert property (grant[4] || grant[5] || grant[6]
    |-> push_class == 4'h8)
    else $error("parser fault not a command error");
  a_selftest_source: assert property (grant[7]
    |-> push_class == 4'h2)
    else $error("self-test fault not a device error");
  a_one_grant: assert property ($onehot0(grant))
    else $error("more than one source granted");
  a_in_range: assert property (PARAM_CHECK && $signed(PARAM_VALUE) >= $signed(limit_lo)
    && $signed(PARAM_VALUE) <= $signed(limit_hi) |-> !range_fail)
    else $error("in-range value raised an execution error");

  // Queue bookkeeping around the corner cases of clear, drain and overflow.
  a_push_lands: assert property (push && !full && !pop && !cls
    |=> count == $past(count) + CW'(1))
    else $error("push did not add an entry");
  a_overflow_hold: assert property (overflow
    |=> rd_ptr == $past(rd_ptr) && wr_ptr == $past(wr_ptr))
    else $error("overflow moved a pointer");
  a_ext_taken: assert property (ERR_VALID
    |-> push && push_code == ERR_CODE)
    else $error("external report not taken");
  a_clear_sole: assert property (cls && push
    |=> count == CW'(1) && mem_code[0] == $past(push_code))
    else $error("push beside clear-status not kept alone");
  a_drain_empty: assert property (pop && count == CW'(1) && !push && !cls
    |=> count == '0)
    else $error("reading the last entry left the queue filled");
  a_cond_edge: assert property (COND_ACTIVE && !cond_prev
    |=> pending[remote_error_queue_pkg::SRC_COND])
    else $error("new condition not queued");
  a_fp_desc: assert property (push
    |=> FP_DESC == $past(push_desc))
    else $error("description not copied to front panel");
  a_read_idle: assert property (!RD
    |=> RDATA == 32'h00000000)
    else $error("read data stood outside its cycle");
  a_indicator_clear: assert property (ind_en && (read_next || cls) && !push
    |=> !ERROR_INDICATOR)
    else $error("indicator not cleared");
  a_indicator_hold: assert property (!ind_en && !push
    |=> ERROR_INDICATOR == $past(ERROR_INDICATOR))
    else $error("indicator cleared while disabled");

  c_overflow: cover property (overflow);
  c_drain: cover property (pop && count == CW'(1));
  c_clear_push: cover property (cls && push);
  c_requeue: cover property (requeue && COND_ACTIVE);
  c_empty_read: cover property (read_next && count == '0);

endmodule

`default_nettype wire

// ### testbench/remote_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// Remote controller: one-cycle strobes, read data taken in the cycle after the strobe.
module remote_host_model (
  // Clock
  input wire logic CLK,
  // Register port
  output logic [7:0] ADDR,
  output logic [31:0] WDATA,
  output logic WR,
  output logic RD,
  input wire logic [31:0] RDATA
);
  initial begin
    ADDR = 8'h00;
    WDATA = 32'h00000000;
    WR = 1'b0;
    RD = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    WDATA <= ~d;
  endtask

  // A next-error read pops an entry, so the host never reads ahead of its need.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    d = RDATA;
  endtask
endmodule

`default_nettype wire

// ### testbench/remote_error_queue_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module remote_error_queue_tb;
  localparam int DEPTH = 4;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic [7:0] ADDR;
  logic [31:0] WDATA;
  logic WR;
  logic RD;
  logic [31:0] RDATA;
  logic ERR_VALID = 1'b0;
  logic [15:0] ERR_CODE = 16'h0000;
  logic [15:0] ERR_DESC = 16'h0000;
  logic [15:0] PARAM_VALUE = 16'h0000;
  logic [8:0] src = 9'h000;
  logic FP_PUSH;
  logic [15:0] FP_CODE;
  logic [15:0] FP_DESC;
  logic ERROR_INDICATOR;
  logic [15:0] fp_last = 16'h0000;
  logic [15:0] fp_desc = 16'h0000;
  logic [15:0] icode [8] = '{16'hfe5c, 16'hfe66, 16'hff22, 16'hff23, 16'hff9a, 16'hff98, 16'hff8f, 16'hfeb6};
  int ibit [8] = '{2, 2, 4, 4, 5, 5, 5, 3};
  int n_mismatch = 0;
  int n_checks = 0;
  int fp_n = 0;
  int cycles = 0;

  initial begin
    forever #20 CLK = ~CLK;
  end

  remote_host_model i_remote_host_model (.CLK(CLK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));

  remote_error_queue #(.DEPTH(DEPTH)) i_remote_error_queue (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .ERR_VALID(ERR_VALID), .ERR_CODE(ERR_CODE), .ERR_DESC(ERR_DESC),
    .QUERY_UNTERMINATED(src[0]), .QUERY_LOST(src[1]), .PARAM_CHECK(src[2]), .PARAM_VALUE(PARAM_VALUE),
    .STATE_CONFLICT(src[3]), .SYNTAX_ERR(src[4]), .DATA_TYPE_ERR(src[5]), .HEADER_ERR(src[6]),
    .SELFTEST_FAIL(src[7]), .COND_ACTIVE(src[8]), .FP_PUSH(FP_PUSH), .FP_CODE(FP_CODE), .FP_DESC(FP_DESC),
    .ERROR_INDICATOR(ERROR_INDICATOR));

  // The front-panel copy is counted here so every test can see whether a push reached it.
  always @(posedge CLK) begin
    if (FP_PUSH === 1'b1) begin
      fp_n++;
      fp_last = FP_CODE;
      fp_desc = FP_DESC;
    end
  end

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  function automatic logic [31:0] st(input logic ind, input logic [5:0] cnt, input logic [7:0] esr);
    return {15'h0000, ind, 2'b00, cnt, esr};
  endfunction

  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    i_remote_host_model.rd(a, d);
    `CHK(d, e)
  endtask

  task automatic push(input logic [15:0] c, input logic [15:0] dsc);
    @(posedge CLK);
    ERR_VALID <= 1'b1;
    ERR_CODE <= c;
    ERR_DESC <= dsc;
    @(posedge CLK);
    ERR_VALID <= 1'b0;
    ERR_CODE <= ~c;
    ERR_DESC <= ~dsc;
  endtask

  task automatic pulse(input int i);
    @(posedge CLK);
    src[i] <= 1'b1;
    @(posedge CLK);
    src[i] <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask

  task automatic t_reset();
    rdx(8'h04, 32'h00000000);
    rdx(8'h08, 32'h00000002);
    rdx(8'h0c, 32'h00008000);
    rdx(8'h10, 32'h00007fff);
    rdx(8'h14, 32'h00000000);
    rdx(8'h00, 32'h00000000);
    $display("test reset done");
  endtask

  // Both ends of every negative class range, one batch each, read back in arrival order.
  task automatic t_classes();
    logic [15:0] c [2][4] = '{'{16'hfe70, 16'hfed4, 16'hff38, 16'hff9c}, '{16'hfe0d, 16'hfe71, 16'hfed5, 16'hff39}};
    for (int j = 0; j < 2; j++) begin
      for (int k = 0; k < 4; k++) push(c[j][k], 16'(k + 16'h0011));
      repeat (2) @(posedge CLK);
      `CHK(fp_last, c[j][3])
      `CHK(fp_desc, 16'h0014)
      rdx(8'h04, st(1'b1, 6'd4, 8'h3c));
      for (int k = 0; k < 4; k++) rdx(8'h00, {16'(k + 16'h0011), c[j][k]});
      rdx(8'h04, st(1'b0, 6'd0, 8'h3c));
      rdx(8'h00, 32'h00000000);
      i_remote_host_model.wr(8'h08, 32'h00000003);
      rdx(8'h04, 32'h00000000);
    end
    `CHK(fp_n, 8)
    $display("test classes done");
  endtask

  task automatic t_overflow();
    push(16'h00c9, 16'h0001);
    push(16'h02bf, 16'h0002);
    push(16'h0320, 16'h0003);
    push(16'h032a, 16'h0004);
    push(16'h02c0, 16'h0005);
    rdx(8'h04, st(1'b1, 6'(DEPTH), 8'h08));
    rdx(8'h00, 32'h000100c9);
    rdx(8'h00, 32'h000202bf);
    rdx(8'h00, 32'h00030320);
    rdx(8'h00, 32'h0100fea2);
    i_remote_host_model.wr(8'h08, 32'h00000003);
    $display("test overflow done");
  endtask

  task automatic t_internal();
    i_remote_host_model.wr(8'h10, 32'h00000064);
    @(posedge CLK);
    PARAM_VALUE <= 16'h0064;
    pulse(2);
    rdx(8'h04, 32'h00000000);
    @(posedge CLK);
    PARAM_VALUE <= 16'h0065;
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      rdx(8'h04, st(1'b1, 6'd1, 8'(1 << ibit[i])));
      rdx(8'h00, {16'(1 << i), icode[i]});
      i_remote_host_model.wr(8'h08, 32'h00000003);
    end
    $display("test internal done");
  endtask

  task automatic t_persist();
    @(posedge CLK);
    src[8] <= 1'b1;
    repeat (4) @(posedge CLK);
    i_remote_host_model.wr(8'h08, 32'h00000003);
    repeat (4) @(posedge CLK);
    rdx(8'h04, st(1'b1, 6'd1, 8'h08));
    rdx(8'h00, 32'h01000201);
    repeat (4) @(posedge CLK);
    rdx(8'h04, st(1'b1, 6'd1, 8'h08));
    @(posedge CLK);
    src[8] <= 1'b0;
    rdx(8'h00, 32'h01000201);
    rdx(8'h04, st(1'b0, 6'd0, 8'h08));
    i_remote_host_model.wr(8'h08, 32'h00000000);
    push(16'hff9c, 16'h0007);
    rdx(8'h00, 32'h0007ff9c);
    `CHK(ERROR_INDICATOR, 1'b1)
    i_remote_host_model.wr(8'h08, 32'h00000002);
    rdx(8'h00, 32'h00000000);
    `CHK(ERROR_INDICATOR, 1'b0)
    $display("test persist done");
  endtask

  // A queued entry and a changed limit must both fall back on a mid-run reset.
  task automatic t_power_up();
    push(16'hfe70, 16'h0001);
    @(posedge CLK);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    rdx(8'h04, 32'h00000000);
    rdx(8'h10, 32'h00007fff);
    rdx(8'h00, 32'h00000000);
    $display("test power-up done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    t_reset();
    t_classes();
    t_overflow();
    t_internal();
    t_persist();
    t_power_up();
    end_of_test();
  end
endmodule

`default_nettype wire
